/* inc/wwd_pkg.sv */
// windowed watchdog: shared constants, register map and carrier types
// assumes a single 50 MHz system clock and a byte-wide register port
package wwd_pkg;
    localparam int CLK_FREQ_HZ = 50_000_000;
    localparam int LS_FREQ_HZ = 264_000;
    // low-speed period rounded down to whole system cycles
    localparam int LS_DIV_CYC = CLK_FREQ_HZ / LS_FREQ_HZ;
    localparam int CNT_W = 17;
    localparam int OVF_BASE_EXP = 10;
    localparam int WIN_BASE_EXP = 8;
    localparam logic [15:0] ADDR_IMS = 16'hff40;
    localparam logic [15:0] ADDR_KICK = 16'hff99;
    localparam logic [15:0] ADDR_INT_STAT = 16'hff9a;
    localparam logic [15:0] ADDR_INT_MASK = 16'hff9b;
    localparam logic [15:0] ADDR_RESET_CAUSE = 16'hffa8;
    localparam logic [7:0] KICK_CODE = 8'hac;
    localparam logic [7:0] KICK_READ_RUN = 8'h9a;
    localparam logic [7:0] KICK_READ_STOP = 8'h1a;
    localparam logic [7:0] IMS_RESET = 8'h07;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int CAUSE_WDT_BIT = 4;
    localparam int ROM_PAGE_EXP = 12;
    localparam logic [15:0] EXEMPT0_LO = 16'hfb00;
    localparam logic [15:0] EXEMPT0_HI = 16'hffcf;
    localparam logic [15:0] EXEMPT1_LO = 16'hffe0;
    localparam logic [15:0] EXEMPT1_HI = 16'hffff;
    localparam logic [1:0] HOLD_TICKS = 2'h2;

    // option byte: bit7 unused, bits 6:5 window, bit 4 run, bits 3:1 overflow, bit 0 unused
    typedef struct packed {
        logic spare_hi;
        logic [1:0] open_sel;
        logic run_en;
        logic [2:0] ovf_sel;
        logic spare_lo;
    } wwd_opt_t;

    localparam wwd_opt_t OPT_RESET = 8'h00;

    // one bit per reset cause; same layout in status and mask registers
    typedef struct packed {
        logic access;
        logic fetch;
        logic window;
        logic badval;
        logic bitop;
        logic ovf;
    } wwd_evt_t;

    localparam int EVT_W = $bits(wwd_evt_t);
endpackage : wwd_pkg

/* logic/wwd_ls_div.sv */
// low-speed clock divider: one-cycle tick every DIV system cycles
// assumes free-running system clock; the tick stands in for the low-speed clock
`timescale 1ns/1ps
module wwd_ls_div import wwd_pkg::*; #(
    parameter int DIV = LS_DIV_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    output logic tick_o
);
    logic [15:0] div_cnt;
    wire logic last = (div_cnt == 16'(DIV - 1));

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_cnt <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            div_cnt <= last ? 16'h0000 : div_cnt + 16'h0001;
            tick_o <= last;
        end
    end

    chk_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        tick_o |=> !tick_o) else $error("low-speed tick longer than one cycle");
endmodule : wwd_ls_div

/* logic/wwd_area_chk.sv */
// memory area checker: flags fetches and non-exempt data accesses outside the enabled area
// assumes fetch and access strobes come from the CPU on the same clock
`timescale 1ns/1ps
module wwd_area_chk import wwd_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [7:0] ims_i,
    input wire logic fetch_valid_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic acc_valid_i,
    input wire logic [15:0] acc_addr_i,
    output logic fetch_err_o,
    output logic acc_err_o
);
    // enabled area is (ims[3:0]+1) pages of 4 KiB from address zero
    function automatic logic in_area(input logic [15:0] a, input logic [7:0] memory_size_select_register);
        logic [16:0] lim;
        lim = 17'({memory_size_select_register[3:0], {ROM_PAGE_EXP{1'b0}}}) + 17'(1 << ROM_PAGE_EXP);
        return {1'b0, a} < lim;
    endfunction : in_area

    wire logic acc_exempt = (acc_addr_i >= EXEMPT0_LO && acc_addr_i <= EXEMPT0_HI)
        || (acc_addr_i >= EXEMPT1_LO && acc_addr_i <= EXEMPT1_HI);

    assign fetch_err_o = en_i && fetch_valid_i && !in_area(fetch_addr_i, ims_i);
    assign acc_err_o = en_i && acc_valid_i && !acc_exempt
        && !in_area(acc_addr_i, ims_i);

    chk_exempt_access: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        acc_exempt |-> !acc_err_o) else $error("access in exempt range flagged");
    chk_disabled_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !en_i |-> !(fetch_err_o || acc_err_o)) else $error("check active while off");
endmodule : wwd_area_chk

/* logic/wwd_top.sv */
// windowed watchdog: counter, kick checks, reset request, registers, interrupt
// assumes option byte is stable from reset release and CPU strobes share the clock
`timescale 1ns/1ps
module wwd_top import wwd_pkg::*; #(
    parameter int LS_DIV = LS_DIV_CYC
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [7:0] option_byte_i,
    input wire logic [15:0] bus_addr_i,
    input wire logic [7:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    input wire logic bus_bitop_i,
    input wire logic fetch_valid_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic acc_valid_i,
    input wire logic [15:0] acc_addr_i,
    output logic [7:0] bus_rdata_o,
    output logic irq_o,
    output logic wdt_reset_req_o
);
    // last count before overflow for field n
    function automatic logic [CNT_W-1:0] ovf_last(input logic [2:0] n);
        return CNT_W'((1 << (OVF_BASE_EXP + int'(n))) - 1);
    endfunction : ovf_last

    // window opens after (3-w) quarters of the overflow time
    function automatic logic [CNT_W-1:0] open_start(input logic [2:0] n, input logic [1:0] w);
        return CNT_W'((1 << (WIN_BASE_EXP + int'(n))) * (3 - int'(w)));
    endfunction : open_start

    // option byte caught once after reset release
    wwd_opt_t opt;
    logic opt_valid;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            opt <= OPT_RESET;
            opt_valid <= 1'b0;
        end else if (!opt_valid) begin
            opt <= wwd_opt_t'(option_byte_i);
            opt_valid <= 1'b1;
        end
    end

    wire logic run_en = opt_valid && opt.run_en;
    wire logic [CNT_W-1:0] cnt_last = ovf_last(opt.ovf_sel);
    wire logic [CNT_W-1:0] win_start = open_start(opt.ovf_sel, opt.open_sel);

    logic ls_tick;

    wwd_ls_div #(
        .DIV(LS_DIV)
    ) u_div (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .tick_o(ls_tick)
    );

    logic [7:0] memory_size_select_register;
    logic fetch_err;
    logic acc_err;

    wwd_area_chk u_area (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .en_i(run_en),
        .ims_i(memory_size_select_register),
        .fetch_valid_i(fetch_valid_i),
        .fetch_addr_i(fetch_addr_i),
        .acc_valid_i(acc_valid_i),
        .acc_addr_i(acc_addr_i),
        .fetch_err_o(fetch_err),
        .acc_err_o(acc_err)
    );

    // register decode
    wire logic sel_kick = (bus_addr_i == ADDR_KICK);
    wire logic sel_ims = (bus_addr_i == ADDR_IMS);
    wire logic sel_stat = (bus_addr_i == ADDR_INT_STAT);
    wire logic sel_mask = (bus_addr_i == ADDR_INT_MASK);
    wire logic sel_cause = (bus_addr_i == ADDR_RESET_CAUSE);

    // kick checks
    logic [CNT_W-1:0] cnt;
    logic first_done;

    wire logic kick_wr = bus_wr_i && sel_kick;
    wire logic kick_bitop = kick_wr && bus_bitop_i;
    wire logic kick_badval = kick_wr && !bus_bitop_i && (bus_wdata_i != KICK_CODE);
    // first kick after reset release is not subject to the window
    wire logic kick_closed = kick_wr && run_en && first_done && (cnt < win_start);
    wire logic kick_good = kick_wr && !kick_bitop && !kick_badval && !kick_closed;
    wire logic cnt_ovf = ls_tick && run_en && (cnt == cnt_last);

    wwd_evt_t evt;
    assign evt = '{access: acc_err, fetch: fetch_err, window: kick_closed,
        badval: kick_badval, bitop: kick_bitop, ovf: cnt_ovf};
    wire logic any_cause = |evt;

    logic [CNT_W-1:0] next_cnt;
    assign next_cnt = kick_good ? '0 :
        (run_en && ls_tick) ? (cnt_ovf ? '0 : cnt + 1'b1) : cnt;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
            first_done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            first_done <= first_done || kick_wr;
        end
    end

    // reset request: raised at once, released only on a low-speed tick
    // after at least one whole low-speed period has passed
    logic [1:0] hold_cnt;
    wire logic hold_done = ls_tick && (hold_cnt == HOLD_TICKS - 2'h1);

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdt_reset_req_o <= 1'b0;
            hold_cnt <= 2'h0;
        end else if (any_cause) begin
            wdt_reset_req_o <= 1'b1;
            hold_cnt <= 2'h0;
        end else if (wdt_reset_req_o && ls_tick) begin
            hold_cnt <= hold_cnt + 2'h1;
            if (hold_done) begin
                wdt_reset_req_o <= 1'b0;
            end
        end
    end

    // status, mask, cause and memory-size registers
    wwd_evt_t stat;
    wwd_evt_t mask;
    logic [7:0] cause;
    wwd_evt_t next_stat;
    logic [7:0] next_cause;

    // set wins over a write-one clear in the same cycle
    assign next_stat = wwd_evt_t'(evt | (stat & ~((bus_wr_i && sel_stat)
        ? bus_wdata_i[EVT_W-1:0] : EVT_W'(0))));
    // cause register clears on read, a new cause in that cycle still lands
    assign next_cause = (bus_rd_i && sel_cause) ? 8'h00 : cause;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat <= '0;
            mask <= wwd_evt_t'(MASK_RESET[EVT_W-1:0]);
            cause <= 8'h00;
            memory_size_select_register <= IMS_RESET;
            irq_o <= 1'b0;
        end else begin
            stat <= next_stat;
            irq_o <= |(next_stat & ((bus_wr_i && sel_mask)
                ? wwd_evt_t'(bus_wdata_i[EVT_W-1:0]) : mask));
            if (bus_wr_i && sel_mask) begin
                mask <= wwd_evt_t'(bus_wdata_i[EVT_W-1:0]);
            end
            if (bus_wr_i && sel_ims) begin
                memory_size_select_register <= bus_wdata_i;
            end
            cause <= next_cause;
            if (any_cause) begin
                cause[CAUSE_WDT_BIT] <= 1'b1;
            end
        end
    end

    // read path: data stands in the cycle after the strobe only
    logic [7:0] rd_mux;
    wire logic [7:0] kick_rd_val = run_en ? KICK_READ_RUN : KICK_READ_STOP;

    assign rd_mux = sel_kick ? kick_rd_val :
        sel_ims ? memory_size_select_register :
        sel_stat ? 8'(stat) :
        sel_mask ? 8'(mask) :
        sel_cause ? cause : 8'h00;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= 8'h00;
        end else begin
            bus_rdata_o <= bus_rd_i ? rd_mux : 8'h00;
        end
    end

    // cycles the request has stood since its last cause, for the hold check
    logic [15:0] req_age;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_age <= 16'h0000;
        end else if (any_cause) begin
            req_age <= 16'h0000;
        end else if (wdt_reset_req_o && req_age != 16'hffff) begin
            req_age <= req_age + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    chk_cnt_tick_only: assert property (
        !ls_tick && !kick_good |=> $stable(cnt))
        else $error("counter moved without a low-speed tick");
    chk_count_step: assert property (
        run_en && ls_tick && !kick_good && !cnt_ovf |=> cnt == $past(cnt) + 1'b1)
        else $error("counter did not advance on a tick");
    chk_ovf_request: assert property (
        cnt_ovf |=> wdt_reset_req_o && cnt == '0)
        else $error("overflow did not request reset");
    chk_bitop_request: assert property (
        kick_bitop |=> wdt_reset_req_o && stat.bitop)
        else $error("bit write to kick register missed");
    chk_badval_request: assert property (
        kick_wr && !bus_bitop_i && bus_wdata_i != KICK_CODE |=> wdt_reset_req_o)
        else $error("wrong kick value missed");
    chk_bad_keeps_cnt: assert property (
        kick_wr && (bus_bitop_i || bus_wdata_i != KICK_CODE) && !ls_tick |=> $stable(cnt))
        else $error("rejected kick moved the counter");
    chk_closed_kick: assert property (
        kick_wr && run_en && first_done && cnt < win_start |=> stat.window)
        else $error("kick in closed window missed");
    chk_fetch_request: assert property (
        fetch_err |=> wdt_reset_req_o && stat.fetch)
        else $error("illegal fetch missed");
    chk_fetch_low: assert property (
        fetch_valid_i && fetch_addr_i < 16'h1000 |-> !fetch_err)
        else $error("fetch from the first page flagged");
    chk_access_request: assert property (
        acc_err |=> wdt_reset_req_o && stat.access)
        else $error("illegal access missed");
    chk_access_low: assert property (
        acc_valid_i && acc_addr_i < 16'h1000 |-> !acc_err)
        else $error("access to the first page flagged");
    chk_cause_flag: assert property (
        any_cause |=> cause[CAUSE_WDT_BIT])
        else $error("reset cause flag not set");
    chk_cause_sticky: assert property (
        cause[CAUSE_WDT_BIT] && !(bus_rd_i && sel_cause) |=> cause[CAUSE_WDT_BIT])
        else $error("reset cause flag lost without a read");
    chk_cause_clear: assert property (
        bus_rd_i && sel_cause && !any_cause |=> cause == 8'h00)
        else $error("reset cause not cleared by read");
    chk_ovf_limit: assert property (
        cnt_ovf |-> $countones(cnt) == OVF_BASE_EXP + int'(opt.ovf_sel)
            && (cnt >> (OVF_BASE_EXP + int'(opt.ovf_sel))) == '0)
        else $error("overflow at wrong count");
    chk_cnt_range: assert property (
        cnt <= cnt_last)
        else $error("counter beyond overflow count");
    chk_kick_clears: assert property (
        kick_good |=> cnt == '0)
        else $error("good kick did not clear counter");
    chk_first_kick: assert property (
        kick_wr && !bus_bitop_i && bus_wdata_i == KICK_CODE && !first_done |=> cnt == '0)
        else $error("first kick after reset did not clear counter");
    chk_kick_readback: assert property (
        bus_rd_i && sel_kick && opt_valid |=> bus_rdata_o == (opt.run_en ? 8'h9a : 8'h1a))
        else $error("kick register read value wrong");
    chk_stopped_count: assert property (
        !run_en |=> cnt == $past(cnt) || cnt == '0)
        else $error("counter ran while disabled");
    chk_req_on_cause: assert property (
        any_cause |=> wdt_reset_req_o)
        else $error("cause did not raise the reset request");
    chk_req_release: assert property (
        $fell(wdt_reset_req_o) |-> $past(ls_tick) && !$past(any_cause))
        else $error("reset request released off a tick");
    chk_req_hold: assert property (
        $fell(wdt_reset_req_o) |-> req_age >= 16'(LS_DIV))
        else $error("reset request shorter than one low-speed period");
    chk_rdata_idle: assert property (
        !bus_rd_i |=> bus_rdata_o == 8'h00)
        else $error("read data outside the read cycle");
    chk_unmapped_read: assert property (
        bus_rd_i && !(sel_kick || sel_ims || sel_stat || sel_mask || sel_cause)
            |=> bus_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    chk_stat_read: assert property (
        bus_rd_i && sel_stat |=> bus_rdata_o == 8'($past(stat)))
        else $error("status read value wrong");
    chk_irq_level: assert property (
        irq_o == |(stat & mask))
        else $error("interrupt does not follow status and mask");
    chk_stat_sticky: assert property (
        !(bus_wr_i && sel_stat) |=> (stat & $past(stat)) == $past(stat))
        else $error("status bit lost without a clear");
    chk_stat_w1c: assert property (
        bus_wr_i && sel_stat && evt == '0 |=> (stat & $past(bus_wdata_i[EVT_W-1:0])) == '0)
        else $error("status bit not cleared by a one");
    chk_mask_write: assert property (
        bus_wr_i && sel_mask |=> mask == $past(bus_wdata_i[EVT_W-1:0]))
        else $error("mask write lost");
    chk_ims_write: assert property (
        bus_wr_i && sel_ims |=> memory_size_select_register == $past(bus_wdata_i))
        else $error("memory size write lost");

    cov_good_kick: cover property (kick_good && first_done);
    cov_overflow: cover property (cnt_ovf);
    cov_closed_kick: cover property (kick_closed);
    cov_fetch_err: cover property (fetch_err ##1 irq_o);
    cov_req_release: cover property ($fell(wdt_reset_req_o));
endmodule : wwd_top

/* dv/wwd_cpu_model.sv */
// cpu core model: register port writes and reads, fetch and data-access strobes
// assumes it is the only master on the port; every strobe is one cycle wide
`timescale 1ns/1ps
module wwd_cpu_model import wwd_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic [7:0] bus_rdata_i,
    output logic [15:0] bus_addr_o,
    output logic [7:0] bus_wdata_o,
    output logic bus_wr_o,
    output logic bus_rd_o,
    output logic bus_bitop_o,
    output logic fetch_valid_o,
    output logic [15:0] fetch_addr_o,
    output logic acc_valid_o,
    output logic [15:0] acc_addr_o
);
    initial begin
        {bus_addr_o, bus_wdata_o, bus_wr_o, bus_rd_o, bus_bitop_o} = '0;
        {fetch_valid_o, fetch_addr_o, acc_valid_o, acc_addr_o} = '0;
    end

    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bit_op);
        @(posedge clk_sys_i);
        bus_addr_o <= a;
        bus_wdata_o <= d;
        bus_bitop_o <= bit_op;
        bus_wr_o <= 1'b1;
        @(posedge clk_sys_i);
        bus_wr_o <= 1'b0;
        bus_bitop_o <= 1'b0;
        // released data lines must not keep showing the last byte
        bus_wdata_o <= ~d;
    endtask : wr

    task automatic kick();
        wr(ADDR_KICK, KICK_CODE, 1'b0);
    endtask : kick

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        bus_addr_o <= a;
        bus_rd_o <= 1'b1;
        @(posedge clk_sys_i);
        bus_rd_o <= 1'b0;
        #1;
        d = bus_rdata_i;
    endtask : rd

    task automatic strobe(input logic is_fetch, input logic [15:0] a);
        @(posedge clk_sys_i);
        if (is_fetch) begin
            fetch_valid_o <= 1'b1;
            fetch_addr_o <= a;
        end else begin
            acc_valid_o <= 1'b1;
            acc_addr_o <= a;
        end
        @(posedge clk_sys_i);
        fetch_valid_o <= 1'b0;
        acc_valid_o <= 1'b0;
        fetch_addr_o <= ~a;
        acc_addr_o <= ~a;
    endtask : strobe
endmodule : wwd_cpu_model

/* dv/testbench.sv */
// watchdog testbench: one task per scenario, cpu model drives the far side
// assumes a shortened low-speed divider so overflow runs stay short
`timescale 1ns/1ps
module testbench import wwd_pkg::*;;
    localparam int LSD = 4;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    wwd_opt_t opt = OPT_RESET;
    logic [15:0] addr, faddr, aaddr;
    logic [7:0] wdata, rdata, d;
    logic wr, rd, bop, fv, av, irq, req;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    always #10 clk_sys = ~clk_sys;

    wwd_cpu_model cpu (.clk_sys_i(clk_sys), .bus_rdata_i(rdata), .bus_addr_o(addr),
        .bus_wdata_o(wdata), .bus_wr_o(wr), .bus_rd_o(rd), .bus_bitop_o(bop),
        .fetch_valid_o(fv), .fetch_addr_o(faddr), .acc_valid_o(av), .acc_addr_o(aaddr));
    wwd_top #(.LS_DIV(LSD)) dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .option_byte_i(opt),
        .bus_addr_i(addr), .bus_wdata_i(wdata), .bus_wr_i(wr), .bus_rd_i(rd),
        .bus_bitop_i(bop), .fetch_valid_i(fv), .fetch_addr_i(faddr), .acc_valid_i(av),
        .acc_addr_i(aaddr), .bus_rdata_o(rdata), .irq_o(irq), .wdt_reset_req_o(req));

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic restart(input logic [1:0] w, input logic on, input logic [2:0] n);
        @(posedge clk_sys);
        opt <= {1'b0, w, on, n, 1'b0};
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask : restart

    // req is a level, so any high sample inside the span counts
    task automatic expect_req(input logic exp, input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (req === 1'b1 && seen === 1'b0) seen = 1'b1;
            // an unknown request must never pass as quiet or as raised
            if (req !== 1'b0 && req !== 1'b1) seen = 1'bx;
        end
        check("reset request", {7'h00, exp}, {7'h00, seen});
    endtask : expect_req

    task automatic expect_rd(input string what, input logic [15:0] a, input logic [7:0] exp);
        cpu.rd(a, d);
        check(what, exp, d);
    endtask : expect_rd

    task automatic t_idle_reads();
        restart(2'h3, 1'b1, 3'h0);
        expect_rd("kick read", ADDR_KICK, KICK_READ_RUN);
        expect_rd("size select", ADDR_IMS, IMS_RESET);
        expect_rd("mask", ADDR_INT_MASK, MASK_RESET);
        expect_rd("unmapped", 16'hff00, 8'h00);
        expect_rd("cause", ADDR_RESET_CAUSE, 8'h00);
        restart(2'h3, 1'b0, 3'h0);
        expect_rd("kick read", ADDR_KICK, KICK_READ_STOP);
        cpu.strobe(1'b1, 16'hf000);
        expect_req(1'b0, 2 * LSD);
    endtask : t_idle_reads

    task automatic t_bad_value();
        restart(2'h3, 1'b1, 3'h0);
        cpu.wr(ADDR_INT_MASK, 8'h04, 1'b0);
        cpu.wr(ADDR_KICK, 8'h5a, 1'b0);
        expect_req(1'b1, 3);
        check("irq", 8'h01, {7'h00, irq});
        expect_rd("status", ADDR_INT_STAT, 8'h04);
        cpu.wr(ADDR_INT_STAT, 8'h04, 1'b0);
        @(posedge clk_sys);
        #1;
        check("irq", 8'h00, {7'h00, irq});
        expect_rd("cause", ADDR_RESET_CAUSE, 8'h10);
    endtask : t_bad_value

    task automatic t_bitop();
        restart(2'h3, 1'b1, 3'h0);
        cpu.wr(ADDR_KICK, KICK_CODE, 1'b1);
        expect_req(1'b1, 3);
        check("irq", 8'h00, {7'h00, irq});
        expect_rd("status", ADDR_INT_STAT, 8'h02);
    endtask : t_bitop

    task automatic t_window();
        // window opens at half the count here, so an early second kick is closed
        restart(2'h1, 1'b1, 3'h0);
        cpu.kick();
        expect_req(1'b0, 8);
        cpu.kick();
        expect_req(1'b1, 3);
        expect_rd("status", ADDR_INT_STAT, 8'h08);
        restart(2'h3, 1'b1, 3'h0);
        cpu.kick();
        cpu.kick();
        expect_req(1'b0, 8);
    endtask : t_window

    task automatic t_overflow(input logic [2:0] n);
        int full;
        full = (1 << (OVF_BASE_EXP + n)) * LSD;
        restart(2'h3, 1'b1, n);
        expect_req(1'b0, full / 2);
        cpu.kick();
        expect_req(1'b0, full - 16);
        expect_req(1'b1, 32);
        expect_rd("status", ADDR_INT_STAT, 8'h01);
    endtask : t_overflow

    task automatic t_area();
        restart(2'h3, 1'b1, 3'h0);
        cpu.strobe(1'b1, 16'h7ffe);
        cpu.strobe(1'b0, EXEMPT0_LO);
        cpu.strobe(1'b0, EXEMPT1_LO);
        expect_req(1'b0, 2 * LSD);
        cpu.strobe(1'b1, 16'h8000);
        expect_req(1'b1, 3);
        expect_rd("status", ADDR_INT_STAT, 8'h10);
        restart(2'h3, 1'b1, 3'h0);
        cpu.strobe(1'b0, 16'hfad0);
        expect_req(1'b1, 3);
        expect_rd("status", ADDR_INT_STAT, 8'h20);
        restart(2'h3, 1'b1, 3'h0);
        cpu.wr(ADDR_IMS, 8'h00, 1'b0);
        expect_rd("size select", ADDR_IMS, 8'h00);
        cpu.strobe(1'b1, 16'h1000);
        expect_req(1'b1, 3);
    endtask : t_area

    initial begin
        t_idle_reads();
        t_bad_value();
        t_bitop();
        t_window();
        t_overflow(3'h0);
        t_overflow(3'h2);
        t_area();
        tally_and_finish();
    end
endmodule : testbench
